// *** tcc_pkg.sv ***
// constants, field layout and state record of the 8-bit timer/counter with two compare units
// assumes an avalon-mm host with 32-bit data and byte addressing, and a 200 MHz clock
//
// Behaviour
// RL1: count value zero is bottom; bottom indication shown whenever counter holds zero.
// RL2: count value all ones is max; max indication shown whenever counter holds it.
// RL3: top is fixed max or compare a value, chosen by waveform mode.
// RL4: tick from prescaler or external pin per clock select; zero select stops counting.
// RL5: software may read and write the count value at any time.
// RL6: software write of count value beats clear, increment or decrement that cycle.
// RL7: counter clears, increments or decrements on each tick, as the mode decides.
// RL8: three-bit waveform mode: two bits in control a, third bit in control b.
// RL9: overflow, compare a, compare b sources, each with a flag and an enable.
// RL10: counter compared to both compare values; match sets flag at next tick.
// RL11: flag and enable raise interrupt; flag clears on service or written one.
// RL12: compare outputs follow match, mode and output-mode bits, with max/bottom cases.
// RL13: compare values double buffered in pwm modes, direct in normal and ctc.
// RL14: buffered compare value moves to active register only at top or bottom.
// RL15: software compare access reaches buffer when buffered, active register otherwise.
// RL16: force strobe in non-pwm modes acts on output as a real match would.
// RL17: forced compare sets no flag and neither clears nor reloads the counter.
// RL18: any count write blocks compare matches during the next tick, even when stopped.
// RL19: software avoids writing count equal to compare, or zero while counting down.
// RL20: compare output states kept unchanged across waveform mode changes.
// RL21: output-mode bit changes act at once, not buffered with the compare value.
// RL22: software clears the power-off control before the timer can run.
// RL23: mode zero counts up, wraps max to zero, sets overflow on reaching zero.
// RL24: mode two clears counter on match with compare a, which sets top.
// RL25: fast pwm uses max as top in mode three, compare a in mode seven.
// RL26: output-mode zero means no output action on match, in every mode.
// RL27: reset clears counter, compare values, flags, masks and modes; timer stopped.
package tcc_pkg;
    localparam int          TCC_ADDR_W     = 5;
    localparam int          TCC_DATA_W     = 32;
    // register indices on address bits 4:2; byte offsets at right
    localparam logic [2:0]  TCC_REG_CTRL_A = 3'h0;   // 0x00
    localparam logic [2:0]  TCC_REG_CTRL_B = 3'h1;   // 0x04
    localparam logic [2:0]  TCC_REG_COUNT  = 3'h2;   // 0x08
    localparam logic [2:0]  TCC_REG_CMP_A  = 3'h3;   // 0x0c
    localparam logic [2:0]  TCC_REG_CMP_B  = 3'h4;   // 0x10
    localparam logic [2:0]  TCC_REG_MASK   = 3'h5;   // 0x14
    localparam logic [2:0]  TCC_REG_FLAG   = 3'h6;   // 0x18
    // field positions
    localparam int          TCC_COM_A_LSB  = 6;
    localparam int          TCC_COM_B_LSB  = 4;
    localparam int          TCC_WGM10_LSB  = 0;
    localparam int          TCC_FOC_A_BIT  = 7;
    localparam int          TCC_FOC_B_BIT  = 6;
    localparam int          TCC_WGM2_BIT   = 3;
    localparam int          TCC_CS_LSB     = 0;
    localparam int          TCC_OVF_BIT    = 0;
    localparam int          TCC_CMPA_BIT   = 1;
    localparam int          TCC_CMPB_BIT   = 2;
    // count range
    localparam logic [7:0]  TCC_BOTTOM     = 8'h00;
    localparam logic [7:0]  TCC_MAX        = 8'hff;
    // waveform modes
    localparam logic [2:0]  TCC_WGM_NORMAL = 3'h0;
    localparam logic [2:0]  TCC_WGM_PC_MAX = 3'h1;
    localparam logic [2:0]  TCC_WGM_CTC    = 3'h2;
    localparam logic [2:0]  TCC_WGM_FP_MAX = 3'h3;
    localparam logic [2:0]  TCC_WGM_PC_CMP = 3'h5;
    localparam logic [2:0]  TCC_WGM_FP_CMP = 3'h7;
    // clock select codes
    localparam logic [2:0]  TCC_CS_STOP    = 3'h0;
    localparam logic [2:0]  TCC_CS_DIRECT  = 3'h1;
    localparam logic [2:0]  TCC_CS_DIV8    = 3'h2;
    localparam logic [2:0]  TCC_CS_DIV64   = 3'h3;
    localparam logic [2:0]  TCC_CS_DIV256  = 3'h4;
    localparam logic [2:0]  TCC_CS_DIV1024 = 3'h5;
    localparam logic [2:0]  TCC_CS_EXT_FALL = 3'h6;
    localparam logic [2:0]  TCC_CS_EXT_RISE = 3'h7;
    // output-mode codes
    localparam logic [1:0]  TCC_COM_OFF    = 2'h0;
    localparam logic [1:0]  TCC_COM_TOGGLE = 2'h1;
    localparam logic [1:0]  TCC_COM_CLEAR  = 2'h2;
    localparam logic [1:0]  TCC_COM_SET    = 2'h3;
    // counting kinds
    localparam logic [1:0]  TCC_KIND_PLAIN = 2'h0;
    localparam logic [1:0]  TCC_KIND_FAST  = 2'h1;
    localparam logic [1:0]  TCC_KIND_PHASE = 2'h2;

    typedef struct packed {
        logic       wait_q;
        logic [7:0] rdata;
        logic [1:0] com_a;
        logic [1:0] com_b;
        logic [2:0] wgm;
        logic [2:0] cs;
        logic [7:0] cnt;
        logic [7:0] cmp_a;
        logic [7:0] cmp_b;
        logic [7:0] buf_a;
        logic [7:0] buf_b;
        logic [2:0] mask;
        logic [2:0] flag;
        logic [2:0] irq;
        logic       oc_a;
        logic       oc_b;
        logic       oc_en_a;
        logic       oc_en_b;
        logic       blk;
        logic       down;
        logic       at_bot;
        logic       at_max;
        logic       ext_s1;
        logic       ext_s2;
        logic       ext_s3;
    } tcc_state_t;

    localparam tcc_state_t TCC_RESET_STATE = '{
        wait_q: 1'b1, at_bot: 1'b1, default: '0};
endpackage

// *** tcc_tb_top.sv ***
// self-checking bench for the timer/counter behind avalon-mm
// assumes tcc_top and tcc_tick_model; ticks come only on request
`timescale 1ns/1ps
module tcc_tb_top;
    import tcc_pkg::*;
    logic        clk_in = 1'b0, srst_in = 1'b1, read_in = 1'b0, write_in = 1'b0, tick_req = 1'b0, ext_pin;
    logic [4:0]  address_in = '0;
    logic [31:0] writedata_in = '0, readdata_out;
    logic [2:0]  irq_ack_in = '0, irq_out;
    logic [3:0]  prescale_tick_in;
    logic        waitrequest_out, oc_a, oc_b, en_a, en_b, at_bot, at_max;
    logic [7:0]  r;
    logic        power_off = 1'b0;
    int          bad_count = 0, checked = 0;
    always #2.5 clk_in = ~clk_in;
    tcc_tick_model tick_src (.tick_req_in(tick_req), .prescale_tick_out(prescale_tick_in), .ext_pin_out(ext_pin));
    tcc_top dut (.clk_in(clk_in), .srst_in(srst_in), .address_in(address_in), .read_in(read_in),
        .write_in(write_in), .byteenable_in(4'h1), .writedata_in(writedata_in), .readdata_out(readdata_out),
        .waitrequest_out(waitrequest_out), .prescale_tick_in(prescale_tick_in), .ext_count_input_in(ext_pin),
        .timer_power_off_in(power_off), .irq_ack_in(irq_ack_in), .irq_out(irq_out), .compare_out_a_out(oc_a),
        .compare_out_b_out(oc_b), .compare_out_a_en_out(en_a), .compare_out_b_en_out(en_b),
        .at_bottom_out(at_bot), .at_max_out(at_max));
    task automatic close_out();
        $display("compares %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            bad_count++;
        end
    endtask
    // one avalon transfer, held until waitrequest is sampled low
    task automatic acc(input logic wr, input logic [2:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clk_in);
        address_in   <= {idx, 2'b00};
        write_in     <= wr;
        read_in      <= !wr;
        writedata_in <= {24'h0, wd};
        do begin
            @(posedge clk_in);
            n++;
        end while (waitrequest_out !== 1'b0 && n < 50);
        if (n >= 50) begin
            bad_count++;
            close_out();
        end
        r = readdata_out[7:0];
        write_in <= 1'b0;
        read_in  <= 1'b0;
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_in) tick_req <= 1'b1;
            @(posedge clk_in) tick_req <= 1'b0;
        end
        repeat (3) @(posedge clk_in);
    endtask
    initial begin
        repeat (20) @(posedge clk_in);
        srst_in <= 1'b0;
        acc(0, TCC_REG_COUNT, 0); chk(r, 8'h00);
        acc(0, TCC_REG_CMP_A, 0); chk(r, 8'h00);
        chk({7'h0, at_bot}, 8'h01);
        acc(1, TCC_REG_COUNT, 8'hff); acc(0, TCC_REG_COUNT, 0); chk(r, 8'hff);
        chk({7'h0, at_max}, 8'h01);
        acc(1, TCC_REG_MASK, 8'h07); acc(1, TCC_REG_CTRL_B, 8'h02);
        tick(1); acc(0, TCC_REG_COUNT, 0); chk(r, 8'h00);
        acc(0, TCC_REG_FLAG, 0); chk(r, 8'h01);
        chk({5'h0, irq_out}, 8'h01);
        acc(1, TCC_REG_FLAG, 8'h01); acc(0, TCC_REG_FLAG, 0); chk(r, 8'h00);
        $display("test overflow done");
        acc(1, TCC_REG_CTRL_A, 8'h02); acc(1, TCC_REG_CMP_A, 8'h03); acc(1, TCC_REG_COUNT, 8'h00);
        tick(3); acc(0, TCC_REG_COUNT, 0); chk(r, 8'h03);
        tick(1); acc(0, TCC_REG_COUNT, 0); chk(r, 8'h00);
        acc(0, TCC_REG_FLAG, 0); chk(r, 8'h02);
        @(posedge clk_in) irq_ack_in <= 3'h2;
        @(posedge clk_in) irq_ack_in <= 3'h0;
        acc(0, TCC_REG_FLAG, 0); chk(r, 8'h00);
        acc(1, TCC_REG_COUNT, 8'h03); tick(1);
        acc(0, TCC_REG_COUNT, 0); chk(r, 8'h04);
        acc(0, TCC_REG_FLAG, 0); chk(r, 8'h00);
        $display("test clear on match done");
        acc(1, TCC_REG_CTRL_A, 8'h70); @(posedge clk_in); chk({7'h0, en_a}, 8'h01);
        acc(1, TCC_REG_CTRL_B, 8'hc2); repeat (2) @(posedge clk_in);
        chk({7'h0, oc_a}, 8'h01);
        chk({6'h0, en_b, oc_b}, 8'h03);
        acc(0, TCC_REG_FLAG, 0); chk(r, 8'h00);
        acc(0, TCC_REG_COUNT, 0); chk(r, 8'h04);
        acc(1, TCC_REG_CTRL_B, 8'h00); tick(2);
        acc(0, TCC_REG_COUNT, 0); chk(r, 8'h04);
        $display("test force and stop done");
        acc(1, TCC_REG_CTRL_A, 8'h43); acc(1, TCC_REG_CMP_B, 8'h20); acc(1, TCC_REG_CMP_A, 8'h10);
        acc(0, TCC_REG_CMP_B, 0); chk(r, 8'h20);
        acc(1, TCC_REG_CTRL_A, 8'h40); acc(0, TCC_REG_CMP_B, 0); chk(r, 8'h00);
        acc(0, TCC_REG_CMP_A, 0); chk(r, 8'h03);
        chk({6'h0, oc_b, oc_a}, 8'h03);
        $display("test double buffer done");
        acc(1, TCC_REG_CTRL_A, 8'h01); acc(1, TCC_REG_COUNT, 8'hfe); acc(1, TCC_REG_CTRL_B, 8'h02);
        tick(2); acc(0, TCC_REG_COUNT, 0); chk(r, 8'hfe);
        power_off <= 1'b1; tick(1); acc(0, TCC_REG_COUNT, 0); chk(r, 8'hfe);
        power_off <= 1'b0;
        acc(1, TCC_REG_CTRL_A, 8'h00); acc(0, TCC_REG_CMP_B, 0); chk(r, 8'h20);
        $display("test phase and power done");
        close_out();
    end
endmodule

// *** tcc_tick_model.sv ***
// partner model: prescaler and count pin seen by the timer
// assumes the bench requests one tick per high cycle of tick_req_in
`timescale 1ns/1ps
module tcc_tick_model (
    // request from bench
    input  wire logic       tick_req_in,
    // tick sources
    output logic      [3:0] prescale_tick_out,
    output logic            ext_pin_out
);
    // one-cycle /8 pulse per request, slower taps idle
    assign prescale_tick_out = {3'h0, tick_req_in};
    assign ext_pin_out       = 1'b0;
endmodule

// *** tcc_top.sv ***
// 8-bit timer/counter with two compare units behind an avalon-mm slave
// assumes prescale ticks are one-cycle pulses on clk_in; the count pin is asynchronous
//
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module tcc_top (
    // clock and reset
    input  wire logic                           clk_in,
    input  wire logic                           srst_in,
    // avalon-mm slave
    input  wire logic [tcc_pkg::TCC_ADDR_W-1:0] address_in,
    input  wire logic                           read_in,
    input  wire logic                           write_in,
    input  wire logic [3:0]                     byteenable_in,
    input  wire logic [tcc_pkg::TCC_DATA_W-1:0] writedata_in,
    output logic      [tcc_pkg::TCC_DATA_W-1:0] readdata_out,
    output logic                                waitrequest_out,
    // tick sources and power
    input  wire logic [3:0]                     prescale_tick_in,
    input  wire logic                           ext_count_input_in,
    input  wire logic                           timer_power_off_in,
    // interrupt service
    input  wire logic [2:0]                     irq_ack_in,
    output logic      [2:0]                     irq_out,
    // compare outputs and indications
    output logic                                compare_out_a_out,
    output logic                                compare_out_b_out,
    output logic                                compare_out_a_en_out,
    output logic                                compare_out_b_en_out,
    output logic                                at_bottom_out,
    output logic                                at_max_out
);
    import tcc_pkg::*;

    tcc_state_t st_reg;
    tcc_state_t st_next;

    logic       timer_tick;
    logic       bus_sel;
    logic       wr_acc;
    logic       wr_cnt;
    logic [2:0] reg_idx;
    logic [7:0] wbyte;
    logic [1:0] kind;
    logic       pwm;
    logic [7:0] top_val;
    logic       at_top;
    logic       match_a;
    logic       match_b;
    logic       tog_a_ok;
    logic       ext_rise;
    logic       ext_fall;

    // one output step for a compare channel
    function automatic logic oc_step(input logic oc, input logic [1:0] com, input logic hit,
                                     input logic wrap, input logic down, input logic [1:0] k,
                                     input logic tog_ok);
        logic r;
        r = oc;
        if (k == TCC_KIND_PLAIN) begin
            if (hit) begin
                case (com)
                    TCC_COM_TOGGLE: r = ~oc;
                    TCC_COM_CLEAR:  r = 1'b0;
                    TCC_COM_SET:    r = 1'b1;
                    default:        r = oc; // see RL26
                endcase
            end
        end else if (k == TCC_KIND_FAST) begin
            if (hit) begin
                case (com)
                    TCC_COM_TOGGLE: r = tog_ok ? ~oc : oc;
                    TCC_COM_CLEAR:  r = 1'b0;
                    TCC_COM_SET:    r = 1'b1;
                    default:        r = oc;
                endcase
            end
            if (wrap) begin
                case (com)
                    TCC_COM_CLEAR:  r = 1'b1; // see RL12
                    TCC_COM_SET:    r = 1'b0;
                    default:        r = r;
                endcase
            end
        end else begin
            if (hit) begin
                case (com)
                    TCC_COM_TOGGLE: r = tog_ok ? ~oc : oc;
                    TCC_COM_CLEAR:  r = down;
                    TCC_COM_SET:    r = ~down;
                    default:        r = oc;
                endcase
            end
        end
        return r;
    endfunction

    // bus decode: one wait cycle, then the access completes
    assign reg_idx = address_in[4:2];
    assign bus_sel = (address_in[1:0] == 2'h0) && byteenable_in[0];
    assign wr_acc  = write_in && !st_reg.wait_q && bus_sel;
    assign wbyte   = writedata_in[7:0];
    assign wr_cnt  = wr_acc && (reg_idx == TCC_REG_COUNT);

    // mode decode
    always_comb begin
        case (st_reg.wgm)
            TCC_WGM_FP_MAX, TCC_WGM_FP_CMP: kind = TCC_KIND_FAST;
            TCC_WGM_PC_MAX, TCC_WGM_PC_CMP: kind = TCC_KIND_PHASE;
            default:                        kind = TCC_KIND_PLAIN;
        endcase
    end
    assign pwm      = (kind != TCC_KIND_PLAIN); // see RL13
    assign tog_a_ok = (st_reg.wgm == TCC_WGM_FP_CMP) || (st_reg.wgm == TCC_WGM_PC_CMP);
    // see RL3 see RL25
    assign top_val  = tog_a_ok ? st_reg.cmp_a : TCC_MAX;
    assign at_top   = (st_reg.cnt == top_val);
    // see RL10 see RL18
    assign match_a  = (st_reg.cnt == st_reg.cmp_a) && !st_reg.blk;
    assign match_b  = (st_reg.cnt == st_reg.cmp_b) && !st_reg.blk;

    // tick selection from the synchronised pin and prescaler taps
    assign ext_rise = st_reg.ext_s2 && !st_reg.ext_s3;
    assign ext_fall = !st_reg.ext_s2 && st_reg.ext_s3;
    always_comb begin
        case (st_reg.cs) // see RL4
            TCC_CS_DIRECT:   timer_tick = 1'b1;
            TCC_CS_DIV8:     timer_tick = prescale_tick_in[0];
            TCC_CS_DIV64:    timer_tick = prescale_tick_in[1];
            TCC_CS_DIV256:   timer_tick = prescale_tick_in[2];
            TCC_CS_DIV1024:  timer_tick = prescale_tick_in[3];
            TCC_CS_EXT_FALL: timer_tick = ext_fall;
            TCC_CS_EXT_RISE: timer_tick = ext_rise;
            default:         timer_tick = 1'b0;
        endcase
        if (timer_power_off_in) begin
            timer_tick = 1'b0; // see RL22
        end
    end

    always_comb begin
        st_next        = st_reg;
        st_next.ext_s1 = ext_count_input_in;
        st_next.ext_s2 = st_reg.ext_s1;
        st_next.ext_s3 = st_reg.ext_s2;
        st_next.wait_q = 1'b1;
        if ((read_in || write_in) && st_reg.wait_q) begin
            st_next.wait_q = 1'b0;
        end
        if (read_in && st_reg.wait_q) begin
            st_next.rdata = 8'h00;
            if (bus_sel) begin
                case (reg_idx)
                    TCC_REG_CTRL_A: begin
                        st_next.rdata[TCC_COM_A_LSB +: 2] = st_reg.com_a;
                        st_next.rdata[TCC_COM_B_LSB +: 2] = st_reg.com_b;
                        st_next.rdata[TCC_WGM10_LSB +: 2] = st_reg.wgm[1:0];
                    end
                    TCC_REG_CTRL_B: begin
                        st_next.rdata[TCC_WGM2_BIT]    = st_reg.wgm[2];
                        st_next.rdata[TCC_CS_LSB +: 3] = st_reg.cs;
                    end
                    TCC_REG_COUNT:  st_next.rdata = st_reg.cnt; // see RL5
                    TCC_REG_CMP_A:  st_next.rdata = pwm ? st_reg.buf_a : st_reg.cmp_a; // see RL15
                    TCC_REG_CMP_B:  st_next.rdata = pwm ? st_reg.buf_b : st_reg.cmp_b;
                    TCC_REG_MASK:   st_next.rdata[2:0] = st_reg.mask;
                    TCC_REG_FLAG:   st_next.rdata[2:0] = st_reg.flag;
                    default:        st_next.rdata = 8'h00;
                endcase
            end
        end

        // flag clear by service or written one, ahead of the tick so a same-cycle set wins
        st_next.flag = st_reg.flag & ~irq_ack_in; // see RL11
        if (wr_acc && (reg_idx == TCC_REG_FLAG)) begin
            st_next.flag = st_next.flag & ~wbyte[2:0];
        end

        // counter, flags and outputs on the timer tick
        st_next.blk = st_reg.blk && !timer_tick;
        if (timer_tick) begin
            if (match_a) begin
                st_next.flag[TCC_CMPA_BIT] = 1'b1;
            end
            if (match_b) begin
                st_next.flag[TCC_CMPB_BIT] = 1'b1;
            end
            st_next.oc_a = oc_step(st_reg.oc_a, st_reg.com_a, match_a, at_top, st_reg.down, kind,
                                   tog_a_ok); // see RL12 see RL21
            st_next.oc_b = oc_step(st_reg.oc_b, st_reg.com_b, match_b, at_top, st_reg.down, kind,
                                   1'b0);
            case (kind) // see RL7
                TCC_KIND_FAST: begin
                    if (at_top) begin
                        st_next.cnt               = TCC_BOTTOM;
                        st_next.flag[TCC_OVF_BIT] = 1'b1;
                        st_next.cmp_a             = st_reg.buf_a; // see RL14
                        st_next.cmp_b             = st_reg.buf_b;
                    end else begin
                        st_next.cnt = st_reg.cnt + 8'h01;
                    end
                end
                TCC_KIND_PHASE: begin
                    if (!st_reg.down) begin
                        if (at_top) begin
                            st_next.down  = 1'b1;
                            st_next.cnt   = st_reg.cnt - 8'h01;
                            st_next.cmp_a = st_reg.buf_a; // see RL14
                            st_next.cmp_b = st_reg.buf_b;
                        end else begin
                            st_next.cnt = st_reg.cnt + 8'h01;
                        end
                    end else if (st_reg.cnt == TCC_BOTTOM) begin
                        st_next.down              = 1'b0;
                        st_next.cnt               = st_reg.cnt + 8'h01;
                        st_next.flag[TCC_OVF_BIT] = 1'b1;
                    end else begin
                        st_next.cnt = st_reg.cnt - 8'h01;
                    end
                end
                default: begin
                    st_next.down = 1'b0;
                    if ((st_reg.wgm == TCC_WGM_CTC) && match_a) begin
                        st_next.cnt = TCC_BOTTOM; // see RL24
                    end else begin
                        st_next.cnt = st_reg.cnt + 8'h01; // see RL23
                    end
                    if (st_reg.cnt == TCC_MAX) begin
                        st_next.flag[TCC_OVF_BIT] = 1'b1;
                    end
                end
            endcase
        end

        // register writes; a count write beats the tick
        if (wr_acc) begin
            case (reg_idx)
                TCC_REG_CTRL_A: begin
                    st_next.com_a    = wbyte[TCC_COM_A_LSB +: 2];
                    st_next.com_b    = wbyte[TCC_COM_B_LSB +: 2];
                    st_next.wgm[1:0] = wbyte[TCC_WGM10_LSB +: 2]; // see RL8 see RL20
                end
                TCC_REG_CTRL_B: begin
                    st_next.wgm[2] = wbyte[TCC_WGM2_BIT];
                    st_next.cs     = wbyte[TCC_CS_LSB +: 3];
                    if (!pwm) begin
                        if (wbyte[TCC_FOC_A_BIT]) begin
                            st_next.oc_a = oc_step(st_next.oc_a, st_reg.com_a, 1'b1, 1'b0, 1'b0,
                                                   TCC_KIND_PLAIN, 1'b1); // see RL16 see RL17
                        end
                        if (wbyte[TCC_FOC_B_BIT]) begin
                            st_next.oc_b = oc_step(st_next.oc_b, st_reg.com_b, 1'b1, 1'b0, 1'b0,
                                                   TCC_KIND_PLAIN, 1'b1);
                        end
                    end
                end
                TCC_REG_COUNT: begin
                    st_next.cnt = wbyte; // see RL6
                    st_next.blk = 1'b1;  // see RL18
                end
                TCC_REG_CMP_A: begin
                    st_next.buf_a = wbyte;
                    if (!pwm) begin
                        st_next.cmp_a = wbyte; // see RL15
                    end
                end
                TCC_REG_CMP_B: begin
                    st_next.buf_b = wbyte;
                    if (!pwm) begin
                        st_next.cmp_b = wbyte;
                    end
                end
                TCC_REG_MASK: st_next.mask = wbyte[2:0]; // see RL9
                default:      st_next.mask = st_next.mask;
            endcase
        end

        st_next.irq     = st_next.flag & st_next.mask; // see RL11
        st_next.oc_en_a = (st_next.com_a != TCC_COM_OFF);
        st_next.oc_en_b = (st_next.com_b != TCC_COM_OFF);
        st_next.at_bot  = (st_next.cnt == TCC_BOTTOM); // see RL1
        st_next.at_max  = (st_next.cnt == TCC_MAX);    // see RL2
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            st_reg <= TCC_RESET_STATE; // see RL27
        end else begin
            st_reg <= st_next;
        end
    end

    assign readdata_out         = {24'h000000, st_reg.rdata};
    assign waitrequest_out      = st_reg.wait_q;
    assign irq_out              = st_reg.irq;
    assign compare_out_a_out    = st_reg.oc_a;
    assign compare_out_b_out    = st_reg.oc_b;
    assign compare_out_a_en_out = st_reg.oc_en_a;
    assign compare_out_b_en_out = st_reg.oc_en_b;
    assign at_bottom_out        = st_reg.at_bot;
    assign at_max_out           = st_reg.at_max;

    default clocking tcc_cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);

    a_count_write_wins: assert property (wr_cnt |=> st_reg.cnt == $past(wbyte)) // see RL6
        else $error("count write did not win");
    a_stopped_holds: assert property ((st_reg.cs == TCC_CS_STOP) && !wr_cnt |=> $stable(st_reg.cnt)) // see RL4
        else $error("counter moved while stopped");
    a_match_sets_flag: assert property (timer_tick && match_a |=> st_reg.flag[TCC_CMPA_BIT]) // see RL10
        else $error("compare a flag not set after match");
    a_block_after_write: assert property (st_reg.blk && timer_tick && !st_reg.flag[TCC_CMPA_BIT]
        && (st_reg.cnt == st_reg.cmp_a) |=> !st_reg.flag[TCC_CMPA_BIT]) // see RL18
        else $error("blocked match set a flag");
    a_force_no_count: assert property (wr_acc && (reg_idx == TCC_REG_CTRL_B) && !timer_tick
        && !st_reg.flag[TCC_CMPA_BIT] |=> $stable(st_reg.cnt) && !st_reg.flag[TCC_CMPA_BIT]) // see RL17
        else $error("forced compare touched counter or flag");
    a_irq_follows_flag: assert property (irq_out == (st_reg.flag & st_reg.mask)) // see RL11
        else $error("interrupt does not follow flag and mask");
    a_normal_wrap: assert property ((st_reg.wgm == TCC_WGM_NORMAL) && timer_tick && !wr_acc
        && (st_reg.cnt == TCC_MAX) |=> (st_reg.cnt == TCC_BOTTOM) && st_reg.flag[TCC_OVF_BIT]) // see RL23
        else $error("normal mode wrap wrong");
    a_ctc_clear: assert property ((st_reg.wgm == TCC_WGM_CTC) && timer_tick && match_a && !wr_acc
        |=> st_reg.cnt == TCC_BOTTOM) // see RL24
        else $error("ctc did not clear on match");
    a_bottom_flag: assert property (at_bottom_out == (st_reg.cnt == TCC_BOTTOM)) // see RL1
        else $error("bottom indication wrong");
    a_max_flag: assert property (at_max_out == (st_reg.cnt == TCC_MAX)) // see RL2
        else $error("max indication wrong");
    a_buffer_holds: assert property (pwm && wr_acc && (reg_idx == TCC_REG_CMP_A) && !timer_tick
        |=> $stable(st_reg.cmp_a) && (st_reg.buf_a == $past(wbyte))) // see RL15
        else $error("buffered write reached active compare");
    a_bus_answer: assert property ((read_in || write_in) && waitrequest_out |=> !waitrequest_out)
        else $error("slave did not answer in one cycle");
    a_power_freeze: assert property (timer_power_off_in && !wr_cnt |=> $stable(st_reg.cnt)) // see RL22
        else $error("counter moved while powered off");
    a_phase_turn: assert property ((kind == TCC_KIND_PHASE) && timer_tick && at_top && !st_reg.down
        && !wr_cnt |=> st_reg.down && (st_reg.cmp_b == $past(st_reg.buf_b))) // see RL14
        else $error("phase pwm did not turn and reload at top");
    a_force_toggle: assert property (wr_acc && (reg_idx == TCC_REG_CTRL_B) && wbyte[TCC_FOC_A_BIT] && !pwm
        && !timer_tick && (st_reg.com_a == TCC_COM_TOGGLE) |=> st_reg.oc_a != $past(st_reg.oc_a)) // see RL16
        else $error("forced toggle did not flip output a");
    a_off_no_action: assert property (timer_tick && match_a && (st_reg.com_a == TCC_COM_OFF) && !wr_acc
        |=> $stable(st_reg.oc_a)) // see RL26
        else $error("output a moved with output mode off");

    c_ctc_clear: cover property ((st_reg.wgm == TCC_WGM_CTC) && timer_tick && match_a);
    c_fast_wrap: cover property ((kind == TCC_KIND_FAST) && timer_tick && at_top);
    c_phase_turn: cover property ((kind == TCC_KIND_PHASE) && timer_tick && st_reg.down
        && (st_reg.cnt == TCC_BOTTOM));
    c_force_a: cover property (wr_acc && (reg_idx == TCC_REG_CTRL_B) && wbyte[TCC_FOC_A_BIT] && !pwm);
    c_phase_top: cover property ((kind == TCC_KIND_PHASE) && timer_tick && at_top && !st_reg.down);
endmodule
